// ### eecnt_defs.vh
// Constants for the E1 error counter and error insertion block.
`ifndef EECNT_DEFS_VH
`define EECNT_DEFS_VH
`define EECNT_A_PRBS    5'h10
`define EECNT_A_PMF     5'h11
`define EECNT_A_FEBE_A  5'h13
`define EECNT_A_FEBE_B  5'h14
`define EECNT_A_JIT     5'h15
`define EECNT_A_OVF     5'h16
`define EECNT_A_FLOSS   5'h17
`define EECNT_A_ABIT    5'h18
`define EECNT_A_AWORD   5'h1a
`define EECNT_A_LCV_L   5'h1c
`define EECNT_A_LCV_H   5'h1d
`define EECNT_A_CRC_A   5'h1e
`define EECNT_A_CRC_B   5'h1f
`define EECNT_OVF_PRBS  0
`define EECNT_OVF_FEBE  1
`define EECNT_OVF_JIT   2
`define EECNT_OVF_FLOSS 3
`define EECNT_OVF_ABIT  4
`define EECNT_OVF_AWORD 5
`define EECNT_OVF_LCV   6
`define EECNT_OVF_CRC   7
`define EECNT_ZERO8     8'h00
`define EECNT_ZERO10    10'h000
`define EECNT_ZERO16    16'h0000
`endif

// ### eecnt_host.sv
// Host processor model on the counter page microport.
`default_nettype none
module eecnt_host (
    // Clock
    input  wire logic       clk,
    // Microport
    output var  logic [4:0] cnt_addr,
    output var  logic       cnt_wr,
    output var  logic       cnt_rd,
    output var  logic [7:0] cnt_wdata,
    input  wire logic [7:0] cnt_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ******************
    // Bus cycles
    // ******************
    logic [7:0] seen;
    event       got;
    initial
    begin
        cnt_addr = 5'h00;
        cnt_wr = 1'b0;
        cnt_rd = 1'b0;
        cnt_wdata = 8'h00;
    end
    // Released data changes so that a stale byte is never mistaken for a write.
    task automatic rel();
        cnt_wr <= 1'b0;
        cnt_wdata <= ~cnt_wdata;
    endtask
    // The strobe stays up on return so back-to-back writes never pulse it twice.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        cnt_addr <= a;
        cnt_wdata <= d;
        cnt_wr <= 1'b1;
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a);
        rel();
        cnt_addr <= a;
        cnt_rd <= 1'b1;
        @(posedge clk);
        cnt_rd <= 1'b0;
        @(negedge clk);
        seen = cnt_rdata;
        -> got;
        @(posedge clk);
    endtask
endmodule // eecnt_host
`default_nettype wire

// ### eecnt_props.sv
// Concurrent checks on the ports of the E1 error counter block.
`default_nettype none
module eecnt_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Counter page microport
    input wire logic [4:0]  cnt_addr,
    input wire logic        cnt_wr,
    input wire logic        cnt_rd,
    input wire logic [7:0]  cnt_rdata,
    // Control and receive events
    input wire logic        counter_clear,
    input wire logic [10:0] irq_mask,
    input wire logic        prbs_err,
    input wire logic        ebit_err,
    input wire logic        jitter_margin,
    input wire logic        frame_loss,
    input wire logic [2:0]  fas_bit_errs,
    input wire logic        lcv_err,
    input wire logic        crc_err,
    // Signal loss control, transmit and interrupt outputs
    input wire logic        inject_signal_loss,
    input wire logic        tx_pos,
    input wire logic        tx_neg,
    input wire logic [10:0] irq_status,
    input wire logic        irq_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ******************
    // Checks
    // ******************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Without any event no counter can overflow, so a cleared latch must read zero.
    wire quiet = !(prbs_err | ebit_err | jitter_margin | frame_loss | lcv_err | crc_err)
                 && fas_bit_errs == 3'h0;
    sequence s_latch_read; cnt_rd && cnt_addr == 5'h16 && quiet ##1 cnt_addr == 5'h16 && quiet;
    endsequence
    sequence s_clear_held; counter_clear ##1 counter_clear && cnt_addr != 5'h16; endsequence
    sequence s_prbs_wr; cnt_wr && cnt_addr == 5'h10 && !counter_clear; endsequence
    property p_irq_pin; irq_n == !(|irq_status); endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq_n wrong");
    property p_prbs_ovf; irq_status[0] |-> $past(prbs_err && irq_mask[0]); endproperty
    a_prbs_ovf: assert property (p_prbs_ovf) else $error("prbs irq wrong");
    property p_febe_event; irq_status[1] |-> $past(ebit_err && irq_mask[1]); endproperty
    a_febe_event: assert property (p_febe_event) else $error("febe irq wrong");
    property p_latch_set; irq_status[0] && cnt_addr == 5'h16 |=> cnt_rdata[0]; endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");
    property p_latch_clear; s_latch_read |=> cnt_rdata == 8'h00; endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");
    property p_clear_held; s_clear_held |=> cnt_rdata == 8'h00; endproperty
    a_clear_held: assert property (p_clear_held) else $error("clear not held");
    property p_mf_clear; s_prbs_wr ##1 cnt_addr == 5'h11 && !cnt_wr |=> cnt_rdata == 8'h00;
    endproperty
    a_mf_clear: assert property (p_mf_clear) else $error("multiframe not cleared");
    property p_clear_quiet; counter_clear |=> irq_status == 11'h000; endproperty
    a_clear_quiet: assert property (p_clear_quiet) else $error("event during clear");
    property p_loss; inject_signal_loss |-> !tx_pos && !tx_neg; endproperty
    a_loss: assert property (p_loss) else $error("signal loss not forced");
endmodule // eecnt_props
`default_nettype wire

// ### eecnt_top.v
// E1 receive error counters, one-second snapshots and transmit error insertion.
`include "eecnt_defs.vh"
`default_nettype none
module eecnt_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Counter page microport
    input  wire [4:0]  cnt_addr,
    input  wire        cnt_wr,
    input  wire        cnt_rd,
    input  wire [7:0]  cnt_wdata,
    output reg  [7:0]  cnt_rdata,
    // Snapshot page microport
    input  wire [4:0]  snap_addr,
    output reg  [7:0]  snap_rdata,
    // Control bits
    input  wire        counter_clear,
    input  wire        one_second,
    input  wire [10:0] irq_mask,
    input  wire        inject_line_code_error,
    input  wire        inject_checksum_error,
    input  wire        inject_alignment_word_error,
    input  wire        inject_non_alignment_word_error,
    input  wire        inject_payload_error,
    input  wire        inject_signal_loss,
    // Receive error events, one-cycle pulses
    input  wire        prbs_err,
    input  wire        rx_multiframe,
    input  wire        ebit_err,
    input  wire        jitter_margin,
    input  wire        frame_loss,
    input  wire [2:0]  fas_bit_errs,
    input  wire        lcv_err,
    input  wire        crc_err,
    // Transmit path
    input  wire        hdb3_pos,
    input  wire        hdb3_neg,
    output wire        tx_pos,
    output wire        tx_neg,
    output wire        tx_bpv_req,
    output wire        tx_crc_req,
    output wire        tx_fas_req,
    output wire        tx_nfas_req,
    output wire        tx_payload_req,
    // Interrupt
    output reg  [10:0] irq_status,
    output wire        irq_n
);

    // ****************************************
    // Counters
    // ****************************************
    reg  [7:0]  prbs_error_count;
    reg  [7:0]  prbs_multiframe_count;
    reg  [9:0]  far_end_block_error_count;
    reg  [7:0]  jitter_fifo_margin_count;
    reg  [7:0]  frame_loss_count;
    reg  [7:0]  alignment_bit_error_count;
    reg  [7:0]  errored_alignment_word_count;
    reg  [15:0] bipolar_violation_count;
    reg  [9:0]  crc_error_count;
    reg  [7:0]  counter_overflow_latch;
    reg  [7:0]  snap_febe_a;
    reg  [7:0]  snap_febe_b;
    reg  [7:0]  snap_aword;
    reg  [15:0] snap_lcv;
    reg  [7:0]  snap_crc_a;
    reg  [7:0]  snap_crc_b;
    reg         one_second_d;

    wire wr_prbs  = cnt_wr && (cnt_addr == `EECNT_A_PRBS);
    wire wr_pmf   = cnt_wr && (cnt_addr == `EECNT_A_PMF);
    wire wr_feba  = cnt_wr && (cnt_addr == `EECNT_A_FEBE_A);
    wire wr_febb  = cnt_wr && (cnt_addr == `EECNT_A_FEBE_B);
    wire wr_jit   = cnt_wr && (cnt_addr == `EECNT_A_JIT);
    wire wr_floss = cnt_wr && (cnt_addr == `EECNT_A_FLOSS);
    wire wr_abit  = cnt_wr && (cnt_addr == `EECNT_A_ABIT);
    wire wr_aword = cnt_wr && (cnt_addr == `EECNT_A_AWORD);
    wire wr_lcvl  = cnt_wr && (cnt_addr == `EECNT_A_LCV_L);
    wire wr_lcvh  = cnt_wr && (cnt_addr == `EECNT_A_LCV_H);
    wire wr_crca  = cnt_wr && (cnt_addr == `EECNT_A_CRC_A);
    wire wr_crcb  = cnt_wr && (cnt_addr == `EECNT_A_CRC_B);
    wire rd_ovf   = cnt_rd && (cnt_addr == `EECNT_A_OVF);

    // Increment qualified so that a host write in the same cycle wins.
    // A held clear also blocks counting, so no overflow or event is reported from it.
    wire live      = !counter_clear;
    wire inc_prbs  = live && prbs_err && !wr_prbs;
    wire inc_pmf   = live && rx_multiframe && !wr_pmf && !wr_prbs;
    wire inc_febe  = live && ebit_err && !wr_feba && !wr_febb;
    wire inc_jit   = live && jitter_margin && !wr_jit;
    wire inc_floss = live && frame_loss && !wr_floss;
    wire inc_abit  = live && (fas_bit_errs != 3'h0) && !wr_abit;
    wire inc_aword = live && (fas_bit_errs != 3'h0) && !wr_aword;
    wire inc_lcv   = live && lcv_err && !wr_lcvl && !wr_lcvh;
    wire inc_crc   = live && crc_err && !wr_crca && !wr_crcb;

    wire [7:0]  abit_sum  = alignment_bit_error_count + {5'h00, fas_bit_errs};
    wire        abit_wrap = inc_abit && (abit_sum < alignment_bit_error_count);
    wire        abit_tog  = inc_abit && (abit_sum[0] != alignment_bit_error_count[0]);

    wire [7:0] ovf_ev;
    assign ovf_ev[`EECNT_OVF_PRBS]  = inc_prbs  && (prbs_error_count == 8'hff);
    assign ovf_ev[`EECNT_OVF_FEBE]  = inc_febe  && (far_end_block_error_count == 10'h3ff);
    assign ovf_ev[`EECNT_OVF_JIT]   = inc_jit   && (jitter_fifo_margin_count == 8'hff);
    assign ovf_ev[`EECNT_OVF_FLOSS] = inc_floss && (frame_loss_count == 8'hff);
    assign ovf_ev[`EECNT_OVF_ABIT]  = abit_wrap;
    assign ovf_ev[`EECNT_OVF_AWORD] = inc_aword && (errored_alignment_word_count == 8'hff);
    assign ovf_ev[`EECNT_OVF_LCV]   = inc_lcv   && (bipolar_violation_count == 16'hffff);
    assign ovf_ev[`EECNT_OVF_CRC]   = inc_crc   && (crc_error_count == 10'h3ff);

    // Counters wrap naturally at their width; each one has a process of its own.
    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            prbs_error_count <= `EECNT_ZERO8;
        end
        else if (wr_prbs)
        begin
            prbs_error_count <= cnt_wdata;
        end
        else if (inc_prbs)
        begin
            prbs_error_count <= prbs_error_count + 8'h01;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            prbs_multiframe_count <= `EECNT_ZERO8;
        end
        else if (wr_prbs)
        begin
            prbs_multiframe_count <= `EECNT_ZERO8;
        end
        else if (wr_pmf)
        begin
            prbs_multiframe_count <= cnt_wdata;
        end
        else if (inc_pmf)
        begin
            prbs_multiframe_count <= prbs_multiframe_count + 8'h01;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            far_end_block_error_count <= `EECNT_ZERO10;
        end
        else if (wr_feba)
        begin
            far_end_block_error_count[7:0] <= cnt_wdata;
        end
        else if (wr_febb)
        begin
            far_end_block_error_count[9:8] <= cnt_wdata[1:0];
        end
        else if (inc_febe)
        begin
            far_end_block_error_count <= far_end_block_error_count + 10'h001;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            jitter_fifo_margin_count <= `EECNT_ZERO8;
        end
        else if (wr_jit)
        begin
            jitter_fifo_margin_count <= cnt_wdata;
        end
        else if (inc_jit)
        begin
            jitter_fifo_margin_count <= jitter_fifo_margin_count + 8'h01;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            frame_loss_count <= `EECNT_ZERO8;
        end
        else if (wr_floss)
        begin
            frame_loss_count <= cnt_wdata;
        end
        else if (inc_floss)
        begin
            frame_loss_count <= frame_loss_count + 8'h01;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            alignment_bit_error_count <= `EECNT_ZERO8;
        end
        else if (wr_abit)
        begin
            alignment_bit_error_count <= cnt_wdata;
        end
        else if (inc_abit)
        begin
            alignment_bit_error_count <= abit_sum;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            errored_alignment_word_count <= `EECNT_ZERO8;
        end
        else if (wr_aword)
        begin
            errored_alignment_word_count <= cnt_wdata;
        end
        else if (inc_aword)
        begin
            errored_alignment_word_count <= errored_alignment_word_count + 8'h01;
        end
    end

    // Each byte is written on its own; low first keeps a carry from corrupting high.
    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            bipolar_violation_count <= `EECNT_ZERO16;
        end
        else if (wr_lcvl)
        begin
            bipolar_violation_count[7:0] <= cnt_wdata;
        end
        else if (wr_lcvh)
        begin
            bipolar_violation_count[15:8] <= cnt_wdata;
        end
        else if (inc_lcv)
        begin
            bipolar_violation_count <= bipolar_violation_count + 16'h0001;
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n || counter_clear)
        begin
            crc_error_count <= `EECNT_ZERO10;
        end
        else if (wr_crca)
        begin
            crc_error_count[7:0] <= cnt_wdata;
        end
        else if (wr_crcb)
        begin
            crc_error_count[9:8] <= cnt_wdata[1:0];
        end
        else if (inc_crc)
        begin
            crc_error_count <= crc_error_count + 10'h001;
        end
    end

    // ****************************************
    // Overflow latch and snapshots
    // ****************************************
    always @(posedge clk)
    begin
        if (!rst_n)
            counter_overflow_latch <= `EECNT_ZERO8;
        else if (rd_ovf)
            counter_overflow_latch <= ovf_ev;
        else
            counter_overflow_latch <= counter_overflow_latch | ovf_ev;
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            one_second_d <= 1'b0;
            snap_febe_a  <= `EECNT_ZERO8;
            snap_febe_b  <= `EECNT_ZERO8;
            snap_aword   <= `EECNT_ZERO8;
            snap_lcv     <= `EECNT_ZERO16;
            snap_crc_a   <= `EECNT_ZERO8;
            snap_crc_b   <= `EECNT_ZERO8;
        end
        else
        begin
            one_second_d <= one_second;
            if (one_second && !one_second_d)
            begin
                snap_febe_a <= far_end_block_error_count[7:0];
                snap_febe_b <= {6'h00, far_end_block_error_count[9:8]};
                snap_aword  <= errored_alignment_word_count;
                snap_lcv    <= bipolar_violation_count;
                snap_crc_a  <= crc_error_count[7:0];
                snap_crc_b  <= {6'h00, crc_error_count[9:8]};
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_rdata  <= `EECNT_ZERO8;
            snap_rdata <= `EECNT_ZERO8;
        end
        else
        begin
            case (cnt_addr)
                `EECNT_A_PRBS:   cnt_rdata <= prbs_error_count;
                `EECNT_A_PMF:    cnt_rdata <= prbs_multiframe_count;
                `EECNT_A_FEBE_A: cnt_rdata <= far_end_block_error_count[7:0];
                `EECNT_A_FEBE_B: cnt_rdata <= {6'h00, far_end_block_error_count[9:8]};
                `EECNT_A_JIT:    cnt_rdata <= jitter_fifo_margin_count;
                `EECNT_A_OVF:    cnt_rdata <= counter_overflow_latch | ovf_ev;
                `EECNT_A_FLOSS:  cnt_rdata <= frame_loss_count;
                `EECNT_A_ABIT:   cnt_rdata <= alignment_bit_error_count;
                `EECNT_A_AWORD:  cnt_rdata <= errored_alignment_word_count;
                `EECNT_A_LCV_L:  cnt_rdata <= bipolar_violation_count[7:0];
                `EECNT_A_LCV_H:  cnt_rdata <= bipolar_violation_count[15:8];
                `EECNT_A_CRC_A:  cnt_rdata <= crc_error_count[7:0];
                `EECNT_A_CRC_B:  cnt_rdata <= {6'h00, crc_error_count[9:8]};
                default:         cnt_rdata <= `EECNT_ZERO8;
            endcase
            case (snap_addr)
                `EECNT_A_FEBE_A: snap_rdata <= snap_febe_a;
                `EECNT_A_FEBE_B: snap_rdata <= snap_febe_b;
                `EECNT_A_AWORD:  snap_rdata <= snap_aword;
                `EECNT_A_LCV_L:  snap_rdata <= snap_lcv[7:0];
                `EECNT_A_LCV_H:  snap_rdata <= snap_lcv[15:8];
                `EECNT_A_CRC_A:  snap_rdata <= snap_crc_a;
                `EECNT_A_CRC_B:  snap_rdata <= snap_crc_b;
                default:         snap_rdata <= `EECNT_ZERO8;
            endcase
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    // Status bits are one-cycle event flags; acknowledgement lives in the vector logic outside.
    wire [10:0] irq_ev;
    assign irq_ev[0]  = ovf_ev[`EECNT_OVF_PRBS];
    assign irq_ev[1]  = inc_febe;
    assign irq_ev[2]  = ovf_ev[`EECNT_OVF_FEBE];
    assign irq_ev[3]  = abit_tog;
    assign irq_ev[4]  = abit_wrap;
    assign irq_ev[5]  = inc_aword;
    assign irq_ev[6]  = ovf_ev[`EECNT_OVF_AWORD];
    assign irq_ev[7]  = inc_lcv;
    assign irq_ev[8]  = ovf_ev[`EECNT_OVF_LCV];
    assign irq_ev[9]  = inc_crc;
    assign irq_ev[10] = ovf_ev[`EECNT_OVF_CRC];

    always @(posedge clk)
    begin
        if (!rst_n)
            irq_status <= 11'h000;
        else
            irq_status <= irq_ev & irq_mask;
    end
    assign irq_n = ~(|irq_status);

    // ****************************************
    // Transmit error insertion
    // ****************************************
    assign tx_bpv_req     = inject_line_code_error;
    assign tx_crc_req     = inject_checksum_error;
    assign tx_fas_req     = inject_alignment_word_error;
    assign tx_nfas_req    = inject_non_alignment_word_error;
    assign tx_payload_req = inject_payload_error;
    assign tx_pos = inject_signal_loss ? 1'b0 : hdb3_pos;
    assign tx_neg = inject_signal_loss ? 1'b0 : hdb3_neg;

endmodule // eecnt_top
`default_nettype wire

// ### eecnt_top_tb.sv
// Self-checking bench for the E1 error counter block.
`default_nettype none
module eecnt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_n;
    logic [4:0]  cnt_addr;
    logic        cnt_wr;
    logic        cnt_rd;
    logic [7:0]  cnt_wdata;
    logic [7:0]  cnt_rdata;
    logic [4:0]  snap_addr;
    logic [7:0]  snap_rdata;
    logic        counter_clear;
    logic        one_second;
    logic [10:0] irq_mask;
    logic [10:0] irq_status;
    logic        irq_n;
    logic [5:0]  inj;
    logic [4:0]  txr;
    logic [1:0]  hdb;
    logic [1:0]  tx;
    logic [6:0]  ev;
    logic [2:0]  fas;
    logic [2:0]  f;
    logic [7:0]  v[14];
    logic [4:0]  ra[14] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18,
                            5'h1a, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
    logic [7:0]  expq[$];
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    // ******************
    // Harness
    // ******************
    eecnt_host host (.clk(clk), .cnt_addr(cnt_addr), .cnt_wr(cnt_wr), .cnt_rd(cnt_rd),
        .cnt_wdata(cnt_wdata), .cnt_rdata(cnt_rdata));
    eecnt_top dut (.clk(clk), .rst_n(rst_n), .cnt_addr(cnt_addr), .cnt_wr(cnt_wr),
        .cnt_rd(cnt_rd), .cnt_wdata(cnt_wdata), .cnt_rdata(cnt_rdata), .snap_addr(snap_addr),
        .snap_rdata(snap_rdata), .counter_clear(counter_clear), .one_second(one_second),
        .irq_mask(irq_mask), .inject_line_code_error(inj[0]), .inject_checksum_error(inj[1]),
        .inject_alignment_word_error(inj[2]), .inject_non_alignment_word_error(inj[3]),
        .inject_payload_error(inj[4]), .inject_signal_loss(inj[5]), .prbs_err(ev[6]),
        .rx_multiframe(ev[5]), .ebit_err(ev[4]), .jitter_margin(ev[3]), .frame_loss(ev[2]),
        .fas_bit_errs(fas), .lcv_err(ev[1]), .crc_err(ev[0]), .hdb3_pos(hdb[1]),
        .hdb3_neg(hdb[0]), .tx_pos(tx[1]), .tx_neg(tx[0]), .tx_bpv_req(txr[0]),
        .tx_crc_req(txr[1]), .tx_fas_req(txr[2]), .tx_nfas_req(txr[3]),
        .tx_payload_req(txr[4]), .irq_status(irq_status), .irq_n(irq_n));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Mode 0 is a preset readback, 1 all zero, 2 one pulse of every event, with f alignment bit errors.
    function automatic logic [7:0] expv(input int i, input int mode);
        logic hi;
        hi = ra[i] == 5'h14 || ra[i] == 5'h1d || ra[i] == 5'h1f;
        if (ra[i] == 5'h12 || ra[i] == 5'h16 || mode == 1)
            return 8'h00;
        if (mode == 2)
            return (ra[i] == 5'h18) ? {5'h00, f} : {7'h00, !hi};
        return (hi && ra[i] != 5'h1d) ? (v[i] & 8'h03) : v[i];
    endfunction
    task automatic rx(input logic [4:0] a, input logic [7:0] e);
        expq.push_back(e);
        host.rd(a);
    endtask
    task automatic wall(input int mode);
        foreach (ra[i])
        begin
            v[i] = mode ? 8'hff : 8'($urandom);
            host.wr(ra[i], v[i]);
        end
    endtask
    task automatic rall(input int mode);
        foreach (ra[i])
            rx(ra[i], expv(i, mode));
    endtask
    task automatic pulse(input logic [6:0] e, input logic [2:0] n);
        host.rel();
        ev <= e;
        fas <= n;
        @(posedge clk);
        ev <= 7'h00;
        fas <= 3'h0;
    endtask
    always @(host.got)
        check("rdata", {3'h0, host.seen}, {3'h0, expq.pop_front()});
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            fails++;
            summarize();
        end
    end
    // ******************
    // Tests
    // ******************
    initial
    begin
        rst_n = 1'b0;
        snap_addr = 5'h00;
        counter_clear = 1'b0;
        one_second = 1'b0;
        irq_mask = 11'h000;
        inj = 6'h00;
        ev = 7'h00;
        fas = 3'h0;
        hdb = 2'b00;
        void'($urandom(40));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("irq_n", {10'h000, irq_n}, 11'h001);
        rall(1);
        $display("test reset done");
        wall(0);
        rall(0);
        host.wr(5'h10, 8'h5a);
        rx(5'h11, 8'h00);
        host.wr(5'h11, 8'hfe);
        pulse(7'h20, 3'h0);
        rx(5'h11, 8'hff);
        $display("test preset done");
        counter_clear <= 1'b1;
        irq_mask <= 11'h7ff;
        pulse(7'h7f, 3'h7);
        @(negedge clk);
        check("irq_clear", irq_status, 11'h000);
        @(posedge clk);
        irq_mask <= 11'h000;
        host.wr(5'h1c, 8'h55);
        rall(1);
        counter_clear <= 1'b0;
        f = 3'($urandom_range(7, 1));
        pulse(7'h7f, f);
        rall(2);
        $display("test count done");
        irq_mask <= 11'($urandom) | 11'h001;
        wall(1);
        rx(5'h16, 8'h00);
        pulse(7'h7f, 3'h1);
        @(negedge clk);
        check("irq_status", irq_status, irq_mask);
        check("irq_n", {10'h000, irq_n}, 11'h000);
        @(posedge clk);
        rx(5'h16, 8'hff);
        rx(5'h16, 8'h00);
        rall(1);
        $display("test wrap done");
        wall(0);
        host.rel();
        one_second <= 1'b1;
        @(posedge clk);
        pulse(7'h7f, 3'h1);
        one_second <= 1'b0;
        foreach (ra[i])
            if (ra[i] inside {5'h13, 5'h14, 5'h1a, 5'h1c, 5'h1d, 5'h1e, 5'h1f})
            begin
                snap_addr <= ra[i];
                @(posedge clk);
                @(negedge clk);
                check("snap", {3'h0, snap_rdata}, {3'h0, expv(i, 0)});
                @(posedge clk);
            end
        $display("test snapshot done");
        repeat (8)
        begin
            inj <= 6'($urandom);
            hdb <= 2'($urandom);
            @(posedge clk);
            @(negedge clk);
            check("tx", {4'h0, tx, txr}, {4'h0, inj[5] ? 2'b00 : hdb, inj[4:0]});
            @(posedge clk);
        end
        $display("test insertion done");
        summarize();
    end
endmodule // eecnt_top_tb
bind eecnt_top eecnt_props u_props (.clk(clk), .rst_n(rst_n), .cnt_addr(cnt_addr),
    .cnt_wr(cnt_wr), .cnt_rd(cnt_rd), .cnt_rdata(cnt_rdata), .counter_clear(counter_clear),
    .irq_mask(irq_mask), .prbs_err(prbs_err), .ebit_err(ebit_err),
    .jitter_margin(jitter_margin), .frame_loss(frame_loss), .fas_bit_errs(fas_bit_errs),
    .lcv_err(lcv_err), .crc_err(crc_err), .inject_signal_loss(inject_signal_loss),
    .tx_pos(tx_pos), .tx_neg(tx_neg), .irq_status(irq_status), .irq_n(irq_n));
`default_nettype wire
